// ---- dv/gfc_regs_sva.sv ----
// Checker on the register bank ports: write responses and control outputs.
// Assumes one clock; reset is the only disable.
`default_nettype none
module gfc_regs_sva
    import gfc_pkg::*;
(
    input wire logic               CORE_CLK,
    input wire logic               RST,
    input wire logic [31:0]        S_AXI_AWADDR,
    input wire logic               S_AXI_AWVALID,
    input wire logic               S_AXI_AWREADY,
    input wire logic [1:0]         S_AXI_BRESP,
    input wire logic               S_AXI_BVALID,
    input wire logic               S_AXI_BREADY,
    input wire logic [1:0]         POWER_MODE_SEL,
    input wire gfc_amp_ctrl_type   AMP_CTRL,
    input wire gfc_input_ctrl_type INPUT_CTRL
);
    logic [31:0] aw_q;
    always_ff @(posedge CORE_CLK) if (S_AXI_AWVALID && S_AXI_AWREADY) aw_q <= S_AXI_AWADDR;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    AST_RESET_ZERO: assert property ($past(RST) |-> AMP_CTRL == '0 && INPUT_CTRL == '0)
        else $error("controls not clear after reset");
    AST_WRITE_RESP: assert property ($rose(S_AXI_BVALID) |-> S_AXI_BRESP ==
        ((aw_q == GFC_AMP_ADDR || aw_q == GFC_INPUT_ADDR) ? GFC_RESP_OKAY : GFC_RESP_SLVERR))
        else $error("bad write response");
    AST_NO_STORE: assert property ($rose(S_AXI_BVALID) && S_AXI_BRESP == GFC_RESP_SLVERR |->
        $stable({AMP_CTRL[7], AMP_CTRL[5:0]}) && $stable(INPUT_CTRL)) else $error("bad store");
    AST_HOLD_STEADY: assert property (!$rose(S_AXI_BVALID) && !$past(RST) |->
        $stable({AMP_CTRL[7], AMP_CTRL[5:0]}) && $stable(INPUT_CTRL)) else $error("controls moved");
    AST_CLAMP_POLARITY: assert property (!$rose(S_AXI_BVALID) && !$past(RST) &&
        !$past(RST, 2) && ($past(POWER_MODE_SEL) == 2'b00) != ($past(POWER_MODE_SEL, 2) == 2'b00)
        |-> AMP_CTRL.current_clamp_en != $past(AMP_CTRL.current_clamp_en)) else $error("clamp");
    AST_RESISTOR_GATE: assert property (!INPUT_CTRL.indiv_resistor_en |->
        INPUT_CTRL.indiv_resistor_code == 5'h00) else $error("resistor code not gated");
    AST_RESP_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
    AST_RESP_RELEASE: assert property ($fell(S_AXI_BVALID) && !$past(RST) |->
        $past(S_AXI_BREADY)) else $error("write response withdrawn");
endmodule : gfc_regs_sva
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the gain and filter register bank.
// Drives the AXI4-Lite port and power mode; checks reads and controls.
`default_nettype none
module tb_top import gfc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, got;
    logic [15:0] v;
    logic [1:0]  pmode = 2'b00, bresp, rresp, rsp;
    gfc_amp_ctrl_type   amp;
    gfc_input_ctrl_type inp;
    int          miscompares = 0, tests_run = 0, cyc = 0;
    logic [3:0]  codes [6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    gfc_regs uut (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .POWER_MODE_SEL(pmode), .AMP_CTRL(amp), .INPUT_CTRL(inp));
    always #20 clk = ~clk;
    function automatic logic [7:0] e_amp(logic [15:0] r, logic [1:0] m);
        return {r[13], (m == 2'b00) ? !r[7] : r[7], r[6], r[4], r[3:0]};
    endfunction : e_amp
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic test_done(input logic to);
        miscompares += int'(to);
        $display("Checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // Leading edge keeps a new request off the edge that closed the last one
    task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d);
        logic hs;
        @(posedge clk);
        {awaddr, araddr, wdata} <= {a, a, 16'($urandom), d};
        {awvalid, wvalid, arvalid} <= {w, w, !w};
        // Response ready raised with the request and held until the answer
        {bready, rready} <= {w, !w};
        do begin
            @(posedge clk);
            {awvalid, wvalid, arvalid} <= {awvalid && !awready, wvalid && !wready,
                arvalid && !arready};
            hs = (bvalid && bready) || (rvalid && rready);
            {bready, rready} <= {bready && !hs, rready && !hs};
        end while (!hs);
        {rsp, got} = {w ? bresp : rresp, rdata};
    endtask : bus
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) test_done(1'b1);
    end
    initial begin
        void'($urandom(32'hb591));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            bus(1'b0, i ? GFC_INPUT_ADDR : GFC_AMP_ADDR, 16'h0000);
            chk("reset_read", 32'h0000_0000, got);
            chk("reset_rresp", 32'(GFC_RESP_OKAY), 32'(rsp));
        end
        for (int i = 0; i < 6; i++) begin
            v = (16'($urandom) & 16'h0050) | {2'h0, i[1], 5'h00, i[0], 3'h0, codes[i]};
            bus(1'b1, GFC_AMP_ADDR, v);
            chk("amp_resp", 32'(GFC_RESP_OKAY), 32'(rsp));
            bus(1'b0, GFC_AMP_ADDR, 16'h0000);
            chk("amp_read", 32'(v), got);
            for (int m = 0; m < 4; m++) begin
                pmode <= 2'(m);
                repeat (2) @(posedge clk);
                chk("amp_ctrl", 32'(e_amp(v, 2'(m))), 32'(amp));
            end
        end
        for (int i = 0; i < 8; i++) begin
            v = (i < 2) ? {10'h000, i[0], 5'h1f} : 16'($urandom) & GFC_INPUT_MASK;
            bus(1'b1, GFC_INPUT_ADDR, v);
            bus(1'b0, GFC_INPUT_ADDR, 16'h0000);
            chk("input_read", 32'(v), got);
            chk("input_ctrl", {17'h0, v[15:12], v[10:5], v[5] ? v[4:0] : 5'h00}, 32'(inp));
        end
        bus(1'b1, 32'h0000_0308, 16'hffff);
        chk("bad_resp", 32'(GFC_RESP_SLVERR), 32'(rsp));
        bus(1'b0, 32'h0000_0308, 16'h0000);
        chk("bad_read", 32'h0000_0000, got);
        chk("bad_rresp", 32'(GFC_RESP_SLVERR), 32'(rsp));
        test_done(1'b0);
    end
endmodule : tb_top
bind gfc_regs gfc_regs_sva u_sva (.CORE_CLK(CORE_CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .POWER_MODE_SEL(POWER_MODE_SEL),
    .AMP_CTRL(AMP_CTRL), .INPUT_CTRL(INPUT_CTRL));
`default_nettype wire

// ---- hdl/gfc_pkg.sv ----
// Constants and types for the gain and filter configuration register bank.
// Assumes an AXI4-Lite master on the single core clock.
// Functional notes
// - Bit 13 of first register picks amplifier gain: 0 is 24 dB, 1 is 30 dB.
// - Power mode 01 or 10: clamp bit 1 turns clamp on, 0 off.
// - Power mode 00: clamp bit 0 turns clamp on, 1 off.
// - Bit 6 sets clamp threshold: 0 is -2 dBFS, 1 is 0 dBFS.
// - Bit 4 set disables the amplifier high-pass filter.
// - Bits 3-0 pick low-pass corner from six defined codes.
// - First register sits at C3h; bits 15-14, 12-8 and 5 reserved.
// - Second register sits at C4h with the given input-stage field layout.
// - All fields read and write, all reset to zero.
// - Per-channel gain enable selects per-channel gains over the global gain.
// - Resistor code applies only while individual-resistor enable is 1.
`default_nettype none

package gfc_pkg;

    localparam logic [31:0] GFC_AMP_ADDR   = 32'h0000_00c3 << 2;
    localparam logic [31:0] GFC_INPUT_ADDR = 32'h0000_00c4 << 2;
    localparam logic [7:0]  GFC_AMP_INDEX   = 8'hc3;
    localparam logic [7:0]  GFC_INPUT_INDEX = 8'hc4;
    localparam logic [15:0] GFC_AMP_RESET   = 16'h0000;
    localparam logic [15:0] GFC_INPUT_RESET = 16'h0000;
    localparam logic [15:0] GFC_AMP_MASK    = 16'h20df;
    localparam logic [15:0] GFC_INPUT_MASK  = 16'hf7ff;
    localparam logic [1:0]  GFC_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  GFC_RESP_SLVERR = 2'b10;
    localparam logic [1:0]  GFC_PMODE_LEGACY = 2'b00;

    localparam int GFC_POST_GAIN_BIT   = 13;
    localparam int GFC_CLAMP_OFF_BIT   = 7;
    localparam int GFC_CLAMP_THR_BIT   = 6;
    localparam int GFC_HPF_OFF_BIT     = 4;
    localparam int GFC_CUTOFF_LSB      = 0;
    localparam int GFC_GAIN_EN_BIT     = 15;
    localparam int GFC_GLB_GAIN_LSB    = 13;
    localparam int GFC_IN_HPF_OFF_BIT  = 12;
    localparam int GFC_IN_CLAMP_LSB    = 9;
    localparam int GFC_TERM_EN_BIT     = 8;
    localparam int GFC_GLB_TERM_LSB    = 6;
    localparam int GFC_RES_EN_BIT      = 5;
    localparam int GFC_RES_CODE_LSB    = 0;

    typedef struct packed {
        logic        post_amp_gain_sel;
        logic        current_clamp_en;
        logic        current_clamp_threshold;
        logic        post_amp_highpass_off;
        logic [3:0]  lowpass_cutoff_code;
    } gfc_amp_ctrl_type;

    typedef struct packed {
        logic        per_channel_gain_en;
        logic [1:0]  global_input_gain;
        logic        input_highpass_off;
        logic [1:0]  input_clamp_level;
        logic        termination_en;
        logic [1:0]  global_termination_sel;
        logic        indiv_resistor_en;
        logic [4:0]  indiv_resistor_code;
    } gfc_input_ctrl_type;

    typedef struct packed {
        logic [15:0] amp_reg;
        logic [15:0] input_reg;
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic        w_held;
        logic [31:0] awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        gfc_amp_ctrl_type   amp_out;
        gfc_input_ctrl_type input_out;
    } gfc_state_type;

endpackage : gfc_pkg

`default_nettype wire

// ---- hdl/gfc_regs.sv ----
// AXI4-Lite register bank driving amplifier, filter and input-stage controls.
// Assumes POWER_MODE_SEL arrives from another register bank on the same clock.
//
// The AXI4-Lite register port was decided locally.
`default_nettype none

module gfc_regs
    import gfc_pkg::*;
(
    input  wire logic               CORE_CLK,
    input  wire logic               RST,
    input  wire logic [31:0]        S_AXI_AWADDR,
    input  wire logic               S_AXI_AWVALID,
    output var  logic               S_AXI_AWREADY,
    input  wire logic [31:0]        S_AXI_WDATA,
    input  wire logic [3:0]         S_AXI_WSTRB,
    input  wire logic               S_AXI_WVALID,
    output var  logic               S_AXI_WREADY,
    output var  logic [1:0]         S_AXI_BRESP,
    output var  logic               S_AXI_BVALID,
    input  wire logic               S_AXI_BREADY,
    input  wire logic [31:0]        S_AXI_ARADDR,
    input  wire logic               S_AXI_ARVALID,
    output var  logic               S_AXI_ARREADY,
    output var  logic [31:0]        S_AXI_RDATA,
    output var  logic [1:0]         S_AXI_RRESP,
    output var  logic               S_AXI_RVALID,
    input  wire logic               S_AXI_RREADY,
    input  wire logic [1:0]         POWER_MODE_SEL,
    output var  gfc_amp_ctrl_type   AMP_CTRL,
    output var  gfc_input_ctrl_type INPUT_CTRL
);

    gfc_state_type state_reg;
    gfc_state_type state_next;
    logic          wr_fire;
    logic          rd_fire;
    logic [15:0]   wr_mask;
    logic [15:0]   amp_new;
    logic [15:0]   input_new;

    always_comb begin
        state_next = state_reg;
        wr_fire    = 1'b0;
        rd_fire    = 1'b0;
        wr_mask    = {{8{state_reg.wstrb[1]}}, {8{state_reg.wstrb[0]}}};
        amp_new    = state_reg.amp_reg;
        input_new  = state_reg.input_reg;

        // Address and data are accepted independently, in either order
        if (S_AXI_AWVALID && state_reg.awready) begin
            state_next.awaddr  = S_AXI_AWADDR;
            state_next.aw_held = 1'b1;
            state_next.awready = 1'b0;
        end
        if (S_AXI_WVALID && state_reg.wready) begin
            state_next.wdata  = S_AXI_WDATA;
            state_next.wstrb  = S_AXI_WSTRB;
            state_next.w_held = 1'b1;
            state_next.wready = 1'b0;
        end

        // Commit once both halves are held and no response is pending
        if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
            wr_fire            = 1'b1;
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = GFC_RESP_OKAY;
            // Reserved bits kept as stored, masked only on the analog side
            unique case (state_reg.awaddr[31:2])
                30'(GFC_AMP_INDEX): begin
                    amp_new = (state_reg.amp_reg & ~wr_mask)
                            | (state_reg.wdata[15:0] & wr_mask);
                end
                30'(GFC_INPUT_INDEX): begin
                    input_new = (state_reg.input_reg & ~wr_mask)
                              | (state_reg.wdata[15:0] & wr_mask);
                end
                default: begin
                    state_next.bresp = GFC_RESP_SLVERR;
                end
            endcase
        end
        state_next.amp_reg   = amp_new;
        state_next.input_reg = input_new;

        if (state_reg.bvalid && S_AXI_BREADY) begin
            state_next.bvalid  = 1'b0;
            state_next.awready = 1'b1;
            state_next.wready  = 1'b1;
        end

        // Read path: one read outstanding, answer one cycle after acceptance
        if (S_AXI_ARVALID && state_reg.arready) begin
            rd_fire            = 1'b1;
            state_next.arready = 1'b0;
            state_next.rvalid  = 1'b1;
            state_next.rresp   = GFC_RESP_OKAY;
            unique case (S_AXI_ARADDR[31:2])
                30'(GFC_AMP_INDEX): begin
                    state_next.rdata = {16'h0000, state_reg.amp_reg};
                end
                30'(GFC_INPUT_INDEX): begin
                    state_next.rdata = {16'h0000, state_reg.input_reg};
                end
                default: begin
                    state_next.rdata = 32'h0000_0000;
                    state_next.rresp = GFC_RESP_SLVERR;
                end
            endcase
        end
        if (state_reg.rvalid && S_AXI_RREADY) begin
            state_next.rvalid  = 1'b0;
            state_next.arready = 1'b1;
        end

        // Analog controls follow stored fields continuously
        state_next.amp_out.post_amp_gain_sel =
            amp_new[GFC_POST_GAIN_BIT];
        // Clamp polarity flips in the legacy power mode; 11 treated as 01/10
        state_next.amp_out.current_clamp_en =
            (POWER_MODE_SEL == GFC_PMODE_LEGACY) ? ~amp_new[GFC_CLAMP_OFF_BIT]
                                                 : amp_new[GFC_CLAMP_OFF_BIT];
        state_next.amp_out.current_clamp_threshold =
            amp_new[GFC_CLAMP_THR_BIT];
        state_next.amp_out.post_amp_highpass_off =
            amp_new[GFC_HPF_OFF_BIT];
        // Undefined codes pass through unchanged; the analog side owns them
        state_next.amp_out.lowpass_cutoff_code =
            amp_new[GFC_CUTOFF_LSB +: 4];

        state_next.input_out.per_channel_gain_en =
            input_new[GFC_GAIN_EN_BIT];
        state_next.input_out.global_input_gain   = input_new[GFC_GLB_GAIN_LSB +: 2];
        state_next.input_out.input_highpass_off  = input_new[GFC_IN_HPF_OFF_BIT];
        state_next.input_out.input_clamp_level   = input_new[GFC_IN_CLAMP_LSB +: 2];
        state_next.input_out.termination_en      = input_new[GFC_TERM_EN_BIT];
        state_next.input_out.global_termination_sel = input_new[GFC_GLB_TERM_LSB +: 2];
        state_next.input_out.indiv_resistor_en   = input_new[GFC_RES_EN_BIT];
        // Code forced to zero unless individual resistor control is on
        state_next.input_out.indiv_resistor_code =
            input_new[GFC_RES_EN_BIT] ? input_new[GFC_RES_CODE_LSB +: 5] : 5'h00;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_reg           <= '0;
            state_reg.amp_reg   <= GFC_AMP_RESET;
            state_reg.input_reg <= GFC_INPUT_RESET;
            state_reg.awready   <= 1'b1;
            state_reg.wready    <= 1'b1;
            state_reg.arready   <= 1'b1;
            // Reset clears controls: clamp enable 0, not the mode 00 value of 1 for clamp bit 0
            state_reg.amp_out.current_clamp_en <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign S_AXI_AWREADY = state_reg.awready;
    assign S_AXI_WREADY  = state_reg.wready;
    assign S_AXI_BVALID  = state_reg.bvalid;
    assign S_AXI_BRESP   = state_reg.bresp;
    assign S_AXI_ARREADY = state_reg.arready;
    assign S_AXI_RVALID  = state_reg.rvalid;
    assign S_AXI_RDATA   = state_reg.rdata;
    assign S_AXI_RRESP   = state_reg.rresp;
    assign AMP_CTRL      = state_reg.amp_out;
    assign INPUT_CTRL    = state_reg.input_out;

    logic unused_bits;
    assign unused_bits = ^{wr_fire, rd_fire, state_reg.wdata[31:16], state_reg.wstrb[3:2]};

endmodule : gfc_regs

`default_nettype wire
